// ==== spcfg_bank_reg.sv ====
// one register held as a buffered copy and an active copy
`timescale 1ns/10ps
module spcfg_bank_reg #(
    parameter int                 W       = 8,
    parameter logic [W-1:0]       RST_VAL = '0
) (
    input  wire logic         clk,      // serial clock
    input  wire logic         rst_n,    // synchronised reset, active low
    input  wire logic         ce,       // clock enable
    input  wire logic         clear,    // soft reset, restores default
    input  wire logic         wr,       // write to buffered copy
    input  wire logic [W-1:0] wdata,    // write data
    input  wire logic         commit,   // copy buffered into active
    output logic      [W-1:0] buf_q,    // buffered copy
    output logic      [W-1:0] act_q     // active copy
);

    // ------------------------------------------------------------
    // buffered copy
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_q <= RST_VAL;
        end else if (ce) begin
            if (clear) begin
                buf_q <= RST_VAL;
            end else if (wr) begin
                buf_q <= wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // active copy
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_q <= RST_VAL;
        end else if (ce) begin
            if (clear) begin
                act_q <= RST_VAL;
            end else if (commit) begin
                act_q <= buf_q;
            end
        end
    end

endmodule // spcfg_bank_reg

// ==== spcfg_host_model.sv ====
// host model driving the register port and read phases of the bank
`timescale 1ns/10ps
module spcfg_host_model (
    input  wire logic       clk,       // serial clock
    input  wire logic [7:0] rdata,     // read data
    input  wire logic       rvalid,    // read data valid
    output logic            wr_en,     // write strobe
    output logic            rd_en,     // read strobe
    output logic      [9:0] addr,      // register address
    output logic      [7:0] wdata,     // write data
    output logic            read_bit,  // bit sent in a read phase
    output logic            read_drive // read phase active
);
    logic gap = 1'b0;
    initial begin
        {wr_en, rd_en, read_bit, read_drive} = 4'h0;
        addr = 10'h000;
        wdata = 8'h00;
    end
    // config byte, upper nibble mirrored, long mode kept
    function automatic logic [7:0] cfg(input logic [2:0] n);
        return {n[0], n[1], n[2], 1'b1, 1'b1, n};
    endfunction
    task automatic write(input logic [9:0] a, input logic [7:0] d);
        if (gap) @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        wdata = ~d;
        gap = 1'b1;
    endtask
    task automatic read(input logic [9:0] a, output logic [7:0] d, output logic v);
        gap = 1'b0;
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        // rvalid stands one cycle only, take it while it stands
        v = rvalid;
        d = rdata;
        rd_en = 1'b0;
        addr = ~a;
        @(negedge clk);
    endtask
    task automatic shift(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            read_drive = 1'b1;
            read_bit = d[i];
            @(negedge clk);
        end
        read_drive = 1'b0;
        read_bit = ~read_bit;
    endtask
endmodule // spcfg_host_model

// ==== spcfg_pkg.sv ====
// constants for the serial port configuration register bank
package spcfg_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_PORT_CONFIGURATION   = 10'h000;
    localparam logic [ADDR_W-1:0] ADDR_VARIANT_IDENTIFIER   = 10'h003;
    localparam logic [ADDR_W-1:0] ADDR_READBACK_BANK_SELECT = 10'h004;
    localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN_AND_SYNC  = 10'h230;
    localparam logic [ADDR_W-1:0] ADDR_RESERVED_SYSTEM      = 10'h231;
    localparam logic [ADDR_W-1:0] ADDR_COMMIT_BUFFERED      = 10'h232;

    // ------------------------------------------------------------
    // port configuration fields
    // ------------------------------------------------------------
    localparam int BIT_OUTPUT_PIN_SELECT = 0;
    localparam int BIT_LSB_FIRST         = 1;
    localparam int BIT_SOFT_RESET        = 2;
    localparam int BIT_LONG_INSTRUCTION  = 3;
    localparam int MIRROR_LO             = 4;

    // ------------------------------------------------------------
    // other fields and reset values
    // ------------------------------------------------------------
    localparam int BIT_READ_ACTIVE = 0;
    localparam int BIT_COMMIT      = 0;
    localparam logic [DATA_W-1:0] RST_PORT_CONFIGURATION = 8'h18;
    localparam logic [DATA_W-1:0] RST_READBACK_SELECT    = 8'h00;
    localparam logic [DATA_W-1:0] RST_POWER_DOWN_SYNC    = 8'h00;
    localparam logic [DATA_W-1:0] RST_RESERVED_SYSTEM    = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO              = 8'h00;

    // arbitrary variant code, not that of any real part
    localparam logic [DATA_W-1:0] VARIANT_ID_DEFAULT = 8'h5a;

endpackage

// ==== spcfg_regs.sv ====
// serial port configuration, identification and update register bank
//
// How it works
// - The long instruction bit picks 8-bit (0) or 16-bit (1) instructions and resets to 1.
// - Soft reset set to 1 holds every other register at default until written back to 0.
// - Bit order 0 means MSB first with falling addresses, 1 means LSB first with rising.
// - With output select 0 the data pin carries both directions and the read pin floats.
// - With output select 1 read data leaves on the read pin, writes still use the data pin.
// - The variant identifier is a fixed read-only byte that ignores writes.
// - Readback select 0 returns buffered copies, 1 returns active copies.
// - The update bit is cleared by the device itself one cycle after the host sets it.
`timescale 1ns/10ps
module spcfg_regs #(
    parameter logic [7:0] VARIANT_ID = spcfg_pkg::VARIANT_ID_DEFAULT // arbitrary code
) (
    input  wire logic                        clk,                 // serial clock, 20 MHz
    input  wire logic                        rst_n,               // async reset, active low
    input  wire logic                        ce,                  // clock enable
    input  wire logic                        wr_en,               // register write strobe
    input  wire logic                        rd_en,               // register read strobe
    input  wire logic [spcfg_pkg::ADDR_W-1:0] addr,               // register address
    input  wire logic [spcfg_pkg::DATA_W-1:0] wdata,              // write data
    input  wire logic                        read_bit,            // read data bit to send
    input  wire logic                        read_drive,          // read phase, drive a pin
    output logic      [spcfg_pkg::DATA_W-1:0] rdata,              // read data
    output logic                             rvalid,              // read data valid pulse
    output logic                             long_instruction,    // 16-bit instructions
    output logic                             lsb_first,           // LSB first, rising addr
    output logic                             output_pin_select,   // separate read pin
    output logic                             soft_reset,          // soft reset in force
    output logic      [spcfg_pkg::DATA_W-1:0] power_down_and_sync, // active setting
    output logic                             sdio_o,              // data pin output
    output logic                             sdio_oe,             // data pin enable
    output logic                             serial_read_out_pin_o,  // read pin output
    output logic                             serial_read_out_pin_oe  // read pin enable
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic hit_cfg;
    logic hit_sel;
    logic hit_pds;
    logic hit_upd;

    assign hit_cfg = addr == spcfg_pkg::ADDR_PORT_CONFIGURATION;
    assign hit_sel = addr == spcfg_pkg::ADDR_READBACK_BANK_SELECT;
    assign hit_pds = addr == spcfg_pkg::ADDR_POWER_DOWN_AND_SYNC;
    assign hit_upd = addr == spcfg_pkg::ADDR_COMMIT_BUFFERED;

    // ------------------------------------------------------------
    // port configuration
    // ------------------------------------------------------------
    logic [spcfg_pkg::DATA_W-1:0] port_configuration;

    // upper nibble is stored as written; host keeps it mirrored
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            port_configuration <= spcfg_pkg::RST_PORT_CONFIGURATION;
        end else if (ce) begin
            if (wr_en && hit_cfg) begin
                port_configuration <= wdata;
            end else if (port_configuration[spcfg_pkg::BIT_SOFT_RESET]) begin
                // hold defaults while soft reset stays set
                port_configuration <= spcfg_pkg::RST_PORT_CONFIGURATION
                                    | (8'h04 & port_configuration);
            end
        end
    end

    logic soft_clear;
    assign soft_clear = port_configuration[spcfg_pkg::BIT_SOFT_RESET];

    // ------------------------------------------------------------
    // readback bank select
    // ------------------------------------------------------------
    logic [spcfg_pkg::DATA_W-1:0] readback_bank_select;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            readback_bank_select <= spcfg_pkg::RST_READBACK_SELECT;
        end else if (ce) begin
            if (soft_clear) begin
                readback_bank_select <= spcfg_pkg::RST_READBACK_SELECT;
            end else if (wr_en && hit_sel) begin
                readback_bank_select <= wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // update control, self clearing
    // ------------------------------------------------------------
    logic commit_buffered_settings;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            commit_buffered_settings <= 1'b0;
        end else if (ce) begin
            commit_buffered_settings <= wr_en && hit_upd && !soft_clear
                                      && wdata[spcfg_pkg::BIT_COMMIT];
        end
    end

    // ------------------------------------------------------------
    // buffered power-down and sync register
    // ------------------------------------------------------------
    logic [spcfg_pkg::DATA_W-1:0] pds_buf;
    logic [spcfg_pkg::DATA_W-1:0] pds_act;

    spcfg_bank_reg #(
        .W       (spcfg_pkg::DATA_W),
        .RST_VAL (spcfg_pkg::RST_POWER_DOWN_SYNC)
    ) u_pds (
        .clk    (clk),
        .rst_n  (rst_sync_n),
        .ce     (ce),
        .clear  (soft_clear),
        .wr     (wr_en && hit_pds),
        .wdata  (wdata),
        .commit (commit_buffered_settings),
        .buf_q  (pds_buf),
        .act_q  (pds_act)
    );

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic                         read_active;
    logic [spcfg_pkg::DATA_W-1:0] next_rdata;

    assign read_active = readback_bank_select[spcfg_pkg::BIT_READ_ACTIVE];

    always_comb begin
        next_rdata = spcfg_pkg::DATA_ZERO;
        unique case (addr)
            spcfg_pkg::ADDR_PORT_CONFIGURATION: begin
                next_rdata = port_configuration;
            end
            spcfg_pkg::ADDR_VARIANT_IDENTIFIER: begin
                next_rdata = VARIANT_ID;
            end
            spcfg_pkg::ADDR_READBACK_BANK_SELECT: begin
                next_rdata = readback_bank_select;
            end
            spcfg_pkg::ADDR_POWER_DOWN_AND_SYNC: begin
                next_rdata = read_active ? pds_act : pds_buf;
            end
            spcfg_pkg::ADDR_RESERVED_SYSTEM: begin
                next_rdata = spcfg_pkg::RST_RESERVED_SYSTEM;
            end
            spcfg_pkg::ADDR_COMMIT_BUFFERED: begin
                next_rdata = {7'h00, commit_buffered_settings};
            end
            default: begin
                next_rdata = spcfg_pkg::DATA_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata  <= spcfg_pkg::DATA_ZERO;
            rvalid <= 1'b0;
        end else if (ce) begin
            rvalid <= rd_en;
            if (rd_en) begin
                rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // mode outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            long_instruction    <= 1'b1;
            lsb_first           <= 1'b0;
            output_pin_select   <= 1'b0;
            soft_reset          <= 1'b0;
            power_down_and_sync <= spcfg_pkg::RST_POWER_DOWN_SYNC;
        end else if (ce) begin
            long_instruction    <= port_configuration[spcfg_pkg::BIT_LONG_INSTRUCTION];
            lsb_first           <= port_configuration[spcfg_pkg::BIT_LSB_FIRST];
            output_pin_select   <= port_configuration[spcfg_pkg::BIT_OUTPUT_PIN_SELECT];
            soft_reset          <= soft_clear;
            power_down_and_sync <= pds_act;
        end
    end

    // ------------------------------------------------------------
    // read data pin steering
    // ------------------------------------------------------------
    logic use_read_pin;
    assign use_read_pin = port_configuration[spcfg_pkg::BIT_OUTPUT_PIN_SELECT];

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sdio_o                 <= 1'b0;
            sdio_oe                <= 1'b0;
            serial_read_out_pin_o  <= 1'b0;
            serial_read_out_pin_oe <= 1'b0;
        end else if (ce) begin
            sdio_o                 <= read_bit;
            sdio_oe                <= read_drive && !use_read_pin;
            serial_read_out_pin_o  <= read_bit;
            serial_read_out_pin_oe <= read_drive && use_read_pin;
        end
    end

endmodule // spcfg_regs

// ==== spcfg_regs_monitor.sv ====
// concurrent checks on the ports of the configuration register bank
`timescale 1ns/10ps
module spcfg_regs_monitor #(
    parameter logic [7:0] VARIANT_ID = spcfg_pkg::VARIANT_ID_DEFAULT // arbitrary code
) (
    input wire logic       clk,                   // serial clock
    input wire logic       rst_n,                 // reset, active low
    input wire logic       ce,                    // clock enable
    input wire logic       wr_en,                 // write strobe
    input wire logic       rd_en,                 // read strobe
    input wire logic [9:0] addr,                  // register address
    input wire logic [7:0] wdata,                 // write data
    input wire logic       read_bit,              // bit to send
    input wire logic       read_drive,            // read phase
    input wire logic [7:0] rdata,                 // read data
    input wire logic       rvalid,                // read valid
    input wire logic       long_instruction,      // long mode
    input wire logic       lsb_first,             // bit order
    input wire logic       output_pin_select,     // separate read pin
    input wire logic       soft_reset,            // soft reset
    input wire logic [7:0] power_down_and_sync,   // active setting
    input wire logic       sdio_o,                // data pin out
    input wire logic       sdio_oe,               // data pin enable
    input wire logic       serial_read_out_pin_o, // read pin out
    input wire logic       serial_read_out_pin_oe // read pin enable
);
    logic rd_req;
    logic commit_req;
    assign rd_req = ce && rd_en;
    assign commit_req = ce && wr_en && addr == 10'h232 && wdata[0];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_oe_data; $past(ce) |-> sdio_oe == ($past(read_drive) && !output_pin_select);
    endproperty
    a_oe_data: assert property (p_oe_data) else $error("data pin enable wrong");
    property p_oe_read; $past(ce) |-> serial_read_out_pin_oe == ($past(read_drive) && output_pin_select);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("read pin enable wrong");
    property p_sdo_val; $past(ce) && sdio_oe |-> sdio_o == $past(read_bit);
    endproperty
    a_sdo_val: assert property (p_sdo_val) else $error("data pin value wrong");
    property p_rdo_val;
        $past(ce) && serial_read_out_pin_oe |-> serial_read_out_pin_o == $past(read_bit);
    endproperty
    a_rdo_val: assert property (p_rdo_val) else $error("read pin value wrong");
    property p_cfg_follow; ce && wr_en && addr == 10'h000 ##1 ce
        |=> ($past(wdata, 2) & 8'h0b) == {4'h0, long_instruction, 1'b0, lsb_first, output_pin_select};
    endproperty
    a_cfg_follow: assert property (p_cfg_follow) else $error("mode outputs wrong");
    property p_soft_def; soft_reset && $past(soft_reset) && $past(ce) && $past(ce, 2) && !$past(wr_en, 2)
        |-> long_instruction && !lsb_first && !output_pin_select && power_down_and_sync == 8'h00;
    endproperty
    a_soft_def: assert property (p_soft_def) else $error("soft reset defaults wrong");
    property p_commit; $changed(power_down_and_sync) |-> $past(soft_reset) || $past(commit_req, 3);
    endproperty
    a_commit: assert property (p_commit) else $error("active setting moved");
    property p_variant; rd_req && addr == 10'h003 |=> rvalid && rdata == VARIANT_ID;
    endproperty
    a_variant: assert property (p_variant) else $error("variant read wrong");
    property p_reserved; rd_req && addr == 10'h231 |=> rvalid && rdata == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read wrong");
    property p_rdata_hold; !$past(rd_req) |-> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    c_soft: cover property (soft_reset && !output_pin_select);
    c_commit: cover property ($changed(power_down_and_sync));
    c_read_pin: cover property (serial_read_out_pin_oe);
endmodule // spcfg_regs_monitor
bind spcfg_regs spcfg_regs_monitor #(.VARIANT_ID(VARIANT_ID)) i_mon (.clk(clk), .rst_n(rst_n),
    .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .read_bit(read_bit),
    .read_drive(read_drive), .rdata(rdata), .rvalid(rvalid), .long_instruction(long_instruction),
    .lsb_first(lsb_first), .output_pin_select(output_pin_select), .soft_reset(soft_reset),
    .power_down_and_sync(power_down_and_sync), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .serial_read_out_pin_o(serial_read_out_pin_o),
    .serial_read_out_pin_oe(serial_read_out_pin_oe));

// ==== tb_top.sv ====
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
module tb_top;
    logic        clk, rst_n, ce, wr_en, rd_en, read_bit, read_drive, rvalid, v;
    logic        long_instruction, lsb_first, output_pin_select, soft_reset;
    logic        sdio_o, sdio_oe, rdo_o, rdo_oe;
    logic [9:0]  addr;
    logic [7:0]  wdata, rdata, power_down_and_sync, d;
    int          bad_count = 0;
    int          checked = 0;
    // address, write data, expected read data
    logic [25:0] rows [8] = '{26'h0009999, 26'h0005a5a, 26'h0001818, 26'h230a5a5, 26'h0040101,
        {10'h003, 8'hff, spcfg_pkg::VARIANT_ID_DEFAULT}, 26'h231ff00, 26'h1ffff00};
    spcfg_regs i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .read_bit(read_bit), .read_drive(read_drive),
        .rdata(rdata), .rvalid(rvalid), .long_instruction(long_instruction),
        .lsb_first(lsb_first), .output_pin_select(output_pin_select), .soft_reset(soft_reset),
        .power_down_and_sync(power_down_and_sync), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
        .serial_read_out_pin_o(rdo_o), .serial_read_out_pin_oe(rdo_oe));
    spcfg_host_model i_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .read_bit(read_bit), .read_drive(read_drive));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        i_host.read(a, d, v);
        chk("rvalid", 8'h01, {7'h00, v});
        chk("rdata", e, d);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("long_instruction", 8'h01, {7'h00, long_instruction});
        rdc(10'h000, spcfg_pkg::RST_PORT_CONFIGURATION);
        $display("test reset done");
        foreach (rows[i]) begin
            i_host.write(rows[i][25:16], rows[i][15:8]);
            rdc(rows[i][25:16], rows[i][7:0]);
        end
        rdc(10'h230, 8'h00);
        i_host.write(10'h232, 8'h01);
        rdc(10'h232, 8'h01);
        rdc(10'h232, 8'h00);
        chk("power_down_and_sync", 8'ha5, power_down_and_sync);
        i_host.write(10'h230, 8'h3c);
        rdc(10'h230, 8'ha5);
        i_host.write(10'h004, 8'h00);
        rdc(10'h230, 8'h3c);
        $display("test commit done");
        i_host.shift(8'hb3);
        chk("pin enables", 8'h01, {6'h00, rdo_oe, sdio_oe});
        chk("sdio_o", 8'h01, {7'h00, sdio_o});
        i_host.write(10'h000, i_host.cfg(3'b001));
        i_host.shift(8'h4d);
        chk("pin enables", 8'h02, {6'h00, rdo_oe, sdio_oe});
        chk("rdo_o", 8'h01, {7'h00, rdo_o});
        i_host.write(10'h000, i_host.cfg(3'b000));
        $display("test pins done");
        i_host.write(10'h004, 8'h01);
        i_host.write(10'h230, 8'h66);
        i_host.write(10'h232, 8'h01);
        i_host.write(10'h000, i_host.cfg(3'b101));
        repeat (3) @(negedge clk);
        chk("soft mode", 8'h06, {5'h00, soft_reset, long_instruction, output_pin_select});
        chk("power_down_and_sync", 8'h00, power_down_and_sync);
        i_host.write(10'h004, 8'h01);
        rdc(10'h004, 8'h00);
        i_host.write(10'h000, i_host.cfg(3'b000));
        rdc(10'h000, 8'h18);
        chk("soft_reset", 8'h00, {7'h00, soft_reset});
        $display("test soft reset done");
        ce = 1'b0;
        i_host.write(10'h004, 8'h01);
        ce = 1'b1;
        rdc(10'h004, 8'h00);
        i_host.write(10'h004, 8'h01);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rdc(10'h004, 8'h00);
        $display("test enable and reset done");
        conclude();
    end
endmodule // tb_top
